// file: logic/tcr_timer.sv
// Capture-restart timer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module tcr_timer #(
  parameter logic [tcr_pkg::IDX_W-1:0] CTL1_IDX = tcr_pkg::IDX_CTL1_T0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic timer_in,
  input wire logic [tcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_irq
);

  typedef struct packed {
    logic wr_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] ctl1;
    logic mhi;
    logic [tcr_pkg::SEL_W-1:0] sel;
    logic flag;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] cap;
    logic irq;
  } tcr_state_t;

  tcr_state_t s;
  tcr_state_t next_s;

  logic en;
  logic pol;
  logic [tcr_pkg::PRESCALE_FIELD_W-1:0] prescale_field;
  logic caprst;
  logic edge_hit;
  logic tick;
  logic cap_hit;
  logic rld_hit;
  logic wr_fire;
  logic rd_fire;
  logic [tcr_pkg::IDX_W-1:0] wr_idx;
  logic [tcr_pkg::IDX_W-1:0] rd_idx;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////
  // Control decode

  assign en = s.ctl1[tcr_pkg::EN_BIT];
  assign pol = s.ctl1[tcr_pkg::POL_BIT];
  assign prescale_field = s.ctl1[tcr_pkg::PRESCALE_FIELD_LSB +: tcr_pkg::PRESCALE_FIELD_W];
  assign caprst = ({s.mhi, s.ctl1[tcr_pkg::MODE_LSB +: tcr_pkg::MODE_W]}
                   == tcr_pkg::MODE_CAPRST);

  tcr_edge u_edge (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sig(timer_in),
    .pol(pol),
    .hit(edge_hit)
  );

  tcr_prescale u_psc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(en),
    .restart(cap_hit),
    .prescale_field(prescale_field),
    .tick(tick)
  );

  assign cap_hit = en && caprst && edge_hit;
  assign rld_hit = tick && !cap_hit && (s.cnt == s.rld);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign wr_fire = s.wr_rdy && s_axi_awvalid && s_axi_wvalid;
  assign rd_fire = s.arready && s_axi_arvalid;
  assign wr_idx = tcr_pkg::reg_idx(s_axi_awaddr);
  assign rd_idx = tcr_pkg::reg_idx(s_axi_araddr);
  assign wr_ok = (wr_idx == tcr_pkg::IDX_CNT) || (wr_idx == tcr_pkg::IDX_RLD)
                 || (wr_idx == tcr_pkg::IDX_CAP) || (wr_idx == tcr_pkg::IDX_CTL0)
                 || (wr_idx == CTL1_IDX);

  always_comb
  begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (rd_idx == tcr_pkg::IDX_CNT)
      rd_val = {16'h0000, s.cnt};
    else if (rd_idx == tcr_pkg::IDX_RLD)
      rd_val = {16'h0000, s.rld};
    else if (rd_idx == tcr_pkg::IDX_CAP)
      rd_val = {16'h0000, s.cap};
    else if (rd_idx == tcr_pkg::IDX_CTL0)
      rd_val = {24'h00_0000, s.mhi, 4'h0, s.sel, s.flag};
    else if (rd_idx == CTL1_IDX)
      rd_val = {24'h00_0000, s.ctl1};
    else
      rd_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    next_s.irq = 1'b0;
    // Timer
    if (cap_hit)
    begin
      next_s.cap = s.cnt;
      next_s.cnt = tcr_pkg::CNT_RESTART;
      next_s.flag = 1'b1;
      next_s.irq = (s.sel != tcr_pkg::SEL_RLD);
    end
    else if (tick)
    begin
      if (s.cnt == s.rld)
      begin
        next_s.cnt = tcr_pkg::CNT_RESTART;
        if (caprst)
          next_s.flag = 1'b0;
        next_s.irq = (s.sel != tcr_pkg::SEL_CAP);
      end
      else
        next_s.cnt = s.cnt + 16'h0001;
    end
    // Write channel
    next_s.wr_rdy = s_axi_awvalid && s_axi_wvalid && !s.wr_rdy && !s.bvalid;
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (wr_fire)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
      // Software writes override the hardware update
      if (wr_idx == tcr_pkg::IDX_CNT)
      begin
        if (s_axi_wstrb[0])
          next_s.cnt[7:0] = s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          next_s.cnt[15:8] = s_axi_wdata[15:8];
      end
      if (wr_idx == tcr_pkg::IDX_RLD)
      begin
        if (s_axi_wstrb[0])
          next_s.rld[7:0] = s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          next_s.rld[15:8] = s_axi_wdata[15:8];
      end
      if (wr_idx == tcr_pkg::IDX_CAP)
      begin
        if (s_axi_wstrb[0])
          next_s.cap[7:0] = s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          next_s.cap[15:8] = s_axi_wdata[15:8];
      end
      if (wr_idx == tcr_pkg::IDX_CTL0 && s_axi_wstrb[0])
      begin
        next_s.mhi = s_axi_wdata[tcr_pkg::MHI_BIT];
        next_s.sel = s_axi_wdata[tcr_pkg::SEL_LSB +: tcr_pkg::SEL_W];
      end
      if (wr_idx == CTL1_IDX && s_axi_wstrb[0])
        next_s.ctl1 = s_axi_wdata[7:0];
    end
    // Read channel
    next_s.arready = s_axi_arvalid && !s.arready && !s.rvalid;
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (rd_fire)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val;
      next_s.rresp = rd_ok ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.ctl1 <= tcr_pkg::CTL_RST;
      s.cnt <= tcr_pkg::CNT_RST;
      s.rld <= tcr_pkg::RLD_RST;
      s.cap <= tcr_pkg::CAP_RST;
      s.bresp <= tcr_pkg::RESP_OKAY;
      s.rresp <= tcr_pkg::RESP_OKAY;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = s.wr_rdy;
  assign s_axi_wready = s.wr_rdy;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timer_irq = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  logic sw_wr_cnt;
  assign sw_wr_cnt = wr_fire && (wr_idx == tcr_pkg::IDX_CNT);

  a_cap_latch: assert property (
    cap_hit && !(wr_fire && wr_idx == tcr_pkg::IDX_CAP) |=> s.cap == $past(s.cnt))
    else $error("capture did not hold the running count");

  a_cap_restart: assert property (
    cap_hit && !sw_wr_cnt |=> s.cnt == tcr_pkg::CNT_RESTART)
    else $error("count not restarted at one after capture");

  a_cap_flag: assert property (
    cap_hit |=> s.flag)
    else $error("capture event flag not set");

  a_rld_restart: assert property (
    rld_hit && !sw_wr_cnt |=> s.cnt == tcr_pkg::CNT_RESTART)
    else $error("count not restarted at one on reload match");

  a_rld_flag: assert property (
    rld_hit && caprst |=> !s.flag)
    else $error("capture event flag not cleared on reload");

  a_irq_cap: assert property (
    cap_hit && s.sel != tcr_pkg::SEL_RLD |=> timer_irq)
    else $error("capture interrupt missing");

  a_irq_mask: assert property (
    rld_hit && s.sel == tcr_pkg::SEL_CAP |=> !timer_irq)
    else $error("reload interrupt not suppressed");

  a_edge_pol: assert property (
    cap_hit |-> (pol ? $fell(timer_in) : $rose(timer_in)))
    else $error("capture on wrong input edge");

  a_stop_hold: assert property (
    !en && !sw_wr_cnt |=> $stable(s.cnt))
    else $error("count moved while disabled");

  a_tick_only: assert property (
    en && !tick && !cap_hit && !sw_wr_cnt |=> $stable(s.cnt))
    else $error("count moved without a prescale tick");

  a_div_two: assert property (
    tick && prescale_field == 3'h1 && $stable(s.ctl1) && !cap_hit ##1 $stable(s.ctl1)
    |-> !tick)
    else $error("prescale by two ticked twice in a row");

  a_ctl_write: assert property (
    wr_fire && wr_idx == CTL1_IDX && s_axi_wstrb[0]
    |=> s.ctl1 == $past(s_axi_wdata[7:0]))
    else $error("control one write lost");

  a_one_cap: assert property (
    cap_hit |=> !cap_hit)
    else $error("two captures from one edge");

  a_cap_prio: assert property (
    cap_hit && tick && !sw_wr_cnt |=> s.cnt == tcr_pkg::CNT_RESTART && s.flag)
    else $error("tick beat a coinciding capture");

  a_cnt_step: assert property (
    tick && !cap_hit && !rld_hit && !sw_wr_cnt |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("count did not step by one on a tick");

  a_mode_gate: assert property (
    edge_hit && !(en && caprst) && !(wr_fire && wr_idx == tcr_pkg::IDX_CAP)
    |=> $stable(s.cap))
    else $error("capture taken while disabled or in another mode");

  a_irq_cause: assert property (
    !cap_hit && !rld_hit |=> !timer_irq)
    else $error("interrupt without a capture or reload event");

  a_flag_keep: assert property (
    !cap_hit && !rld_hit |=> $stable(s.flag))
    else $error("capture event flag moved without an event");

  a_cnt_write: assert property (
    sw_wr_cnt && s_axi_wstrb[1:0] == 2'h3 |=> s.cnt == $past(s_axi_wdata[15:0]))
    else $error("start count write lost");

  a_wr_answer: assert property (
    wr_fire |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered after it was taken");

  a_rd_answer: assert property (
    rd_fire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered after it was taken");

  a_rd_ctl: assert property (
    rd_fire && rd_idx == CTL1_IDX |=> s_axi_rdata == {24'h00_0000, $past(s.ctl1)})
    else $error("control one read data wrong");

  a_bad_write: assert property (
    wr_fire && !wr_ok |=> s_axi_bresp == tcr_pkg::RESP_SLVERR && $stable(s.ctl1))
    else $error("unmapped write not refused");

  a_bad_read: assert property (
    rd_fire && !rd_ok |=> s_axi_rresp == tcr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  c_prescaled: cover property (rld_hit && prescale_field != 3'h0);
  c_capture: cover property (cap_hit ##1 timer_irq);
  c_reload: cover property (rld_hit ##1 timer_irq);
  c_collide: cover property (cap_hit && tick);
  c_slverr: cover property (s.rvalid && s.rresp == tcr_pkg::RESP_SLVERR);

endmodule // tcr_timer
`default_nettype wire

// file: logic/tcr_pkg.sv
// Constants, field layout and register map of the capture-restart timer
package tcr_pkg;

  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CNT = 12'hf00;
  localparam logic [IDX_W-1:0] IDX_RLD = 12'hf01;
  localparam logic [IDX_W-1:0] IDX_CAP = 12'hf02;
  localparam logic [IDX_W-1:0] IDX_CTL0 = 12'hf06;
  localparam logic [IDX_W-1:0] IDX_CTL1_T0 = 12'hf07;
  localparam logic [IDX_W-1:0] IDX_CTL1_T1 = 12'hf0f;

  // Control one fields
  localparam int EN_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PRESCALE_FIELD_LSB = 3;
  localparam int PRESCALE_FIELD_W = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;

  // Control zero fields
  localparam int FLAG_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int SEL_W = 2;
  localparam int MHI_BIT = 7;

  // Full mode code {mode high, mode}
  localparam logic [MODE_W:0] MODE_CAPRST = 4'h8;

  localparam logic [SEL_W-1:0] SEL_BOTH = 2'h0;
  localparam logic [SEL_W-1:0] SEL_CAP = 2'h1;
  localparam logic [SEL_W-1:0] SEL_RLD = 2'h2;

  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RLD_RST = 16'hffff;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [7:0] CTL_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int PSC_W = 8;

  // Register index from a byte address
  function automatic logic [IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] addr);
    reg_idx = addr[ADDR_W-1:2];
  endfunction

endpackage

// file: logic/tcr_edge.sv
// Synchronous edge detector with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module tcr_edge (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sig,
  input wire logic pol,
  output logic hit
);

  typedef struct packed {
    logic armed;
    logic prev;
  } tcr_edge_t;

  tcr_edge_t s;
  tcr_edge_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.armed = 1'b1;
    next_s.prev = sig;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  // Zero picks rising, one picks falling
  // First sample after reset only arms, so a pin idling high gives no false edge
  assign hit = s.armed && (pol ? (s.prev & ~sig) : (~s.prev & sig));

endmodule // tcr_edge
`default_nettype wire

// file: logic/tcr_prescale.sv
// Prescaler giving one tick every 2**prescale_field clocks
`timescale 1ns/1ps
`default_nettype none
module tcr_prescale #(
  parameter int PW = tcr_pkg::PRESCALE_FIELD_W,
  parameter int CW = tcr_pkg::PSC_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic restart,
  input wire logic [PW-1:0] prescale_field,
  output logic tick
);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } tcr_psc_t;

  tcr_psc_t s;
  tcr_psc_t next_s;
  logic [CW-1:0] limit;

  assign limit = CW'((1 << prescale_field) - 1);
  assign tick = run && (s.cnt == limit);

  always_comb
  begin
    next_s = s;
    if (restart || !run || tick)
      next_s.cnt = '0;
    else
      next_s.cnt = s.cnt + CW'(1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

endmodule // tcr_prescale
`default_nettype wire

// file: verif/tcr_pin_model.sv
// Model of the pin that feeds the timer input
`timescale 1ns/1ps
`default_nettype none
module tcr_pin_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic level,
  input wire logic slow,
  output logic timer_in
);
  logic stage;
  // Pin follows the requested level after one clock, or two when slow
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      stage <= 1'b0;
      timer_in <= 1'b0;
    end
    else
    begin
      stage <= level;
      timer_in <= slow ? stage : level;
    end
  end
endmodule // tcr_pin_model
`default_nettype wire

// file: verif/timer_capture_restart_tb.sv
// Self-checking bench for the capture-restart timer
`timescale 1ns/1ps
`default_nettype none
module timer_capture_restart_tb;
  logic sys_clk, rst_b, lvl, slow, timer_in, timer_irq;
  logic [13:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int n_irq = 0;
  int t_irq = 0;
  int t0, t1, r, p, pol, ofs;

  tcr_timer tcr_timer_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .timer_in(timer_in),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_irq(timer_irq));
  tcr_pin_model tcr_pin_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .level(lvl), .slow(slow), .timer_in(timer_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Interrupt time stamps and hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (timer_irq === 1'b1)
    begin
      n_irq++;
      t_irq = cyc;
    end
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_t(input int g, input int e);
    chk(g, e);
  endtask

  task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Each channel is released at the edge its own ready is seen
    do
    begin
      @(posedge sys_clk);
      if (awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!(aw_done && w_done));
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    chk(bresp, er);
  endtask

  task automatic rd_reg(input logic [11:0] i, input logic [1:0] er, output logic [31:0] d);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    chk(rresp, er);
  endtask

  task automatic rchk(input logic [11:0] i, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(i, 2'h0, d);
    chk(d, e);
  endtask

  // Disable, mode, prescale and edge, start count, reload, then enable
  task automatic setup(input int sel, input int pl, input int ps, input int rl);
    wr(tcr_pkg::IDX_CTL1_T0, 32'h0, 2'h0);
    wr(tcr_pkg::IDX_CTL0, 32'h80 | (sel << 1), 2'h0);
    wr(tcr_pkg::IDX_CTL1_T0, (pl << 6) | (ps << 3), 2'h0);
    wr(tcr_pkg::IDX_CNT, 32'h1, 2'h0);
    wr(tcr_pkg::IDX_RLD, rl, 2'h0);
    lvl <= pl[0];
    repeat (4) @(posedge sys_clk);
    wr(tcr_pkg::IDX_CTL1_T0, 32'h80 | (pl << 6) | (ps << 3), 2'h0);
  endtask

  task automatic wait_irq(output int t);
    int n0;
    n0 = n_irq;
    wait (n_irq > n0);
    t = t_irq;
  endtask

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h6a3fee33));
    rst_b = 1'b0;
    lvl = 1'b0;
    slow = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rchk(tcr_pkg::IDX_CNT, {16'h0, tcr_pkg::CNT_RST});
    rchk(tcr_pkg::IDX_RLD, {16'h0, tcr_pkg::RLD_RST});
    rchk(tcr_pkg::IDX_CAP, {16'h0, tcr_pkg::CAP_RST});
    rchk(tcr_pkg::IDX_CTL0, 32'h0);
    rchk(tcr_pkg::IDX_CTL1_T0, 32'h0);
    rd_reg(12'hf03, tcr_pkg::RESP_SLVERR, rd);
    wr(12'hf03, 32'h5a, tcr_pkg::RESP_SLVERR);
    r = $urandom & 32'h7f;
    wr(tcr_pkg::IDX_CTL1_T0, r, 2'h0);
    rchk(tcr_pkg::IDX_CTL1_T0, r);
    // Reload period at prescales 0 to 2 from a random start, random reload value
    ofs = $urandom_range(2);
    for (int k = 0; k < 3; k++)
    begin
      p = (k + ofs) % 3;
      r = $urandom_range(30, 10);
      setup(0, 0, p, r);
      rchk(tcr_pkg::IDX_CTL1_T0, 32'h80 | (p << 3));
      wait_irq(t0);
      wait_irq(t1);
      chk_t(t1 - t0, r << p);
      rchk(tcr_pkg::IDX_CTL0, 32'h80);
    end
    // Capture under every interrupt source selection
    for (int sel = 0; sel < 4; sel++)
    begin
      pol = $urandom_range(1);
      setup(sel, pol, 0, 80);
      t0 = n_irq;
      repeat (100) @(posedge sys_clk);
      chk_t(n_irq > t0, sel != 1);
      repeat ($urandom_range(30)) @(posedge sys_clk);
      t0 = t_irq;
      r = n_irq;
      lvl <= ~pol[0];
      slow <= 1'($urandom);
      repeat (8) @(posedge sys_clk);
      chk_t(n_irq - r, sel != 2);
      if (sel == 0 || sel == 3)
      begin
        t1 = t_irq;
        rchk(tcr_pkg::IDX_CAP, t1 - t0);
        rchk(tcr_pkg::IDX_CTL0, 32'h81 | (sel << 1));
        lvl <= pol[0];
        wait_irq(t0);
        chk_t(t0 - t1, 80);
        rchk(tcr_pkg::IDX_CTL0, 32'h80 | (sel << 1));
      end
    end
    // Stopped timer holds its count and ignores the pin
    wr(tcr_pkg::IDX_CTL1_T0, 32'h0, 2'h0);
    rd_reg(tcr_pkg::IDX_CNT, 2'h0, rd);
    r = n_irq;
    lvl <= ~lvl;
    repeat (50) @(posedge sys_clk);
    lvl <= ~lvl;
    repeat (50) @(posedge sys_clk);
    rchk(tcr_pkg::IDX_CNT, rd);
    chk_t(n_irq, r);
    end_of_test();
  end
endmodule // timer_capture_restart_tb
`default_nettype wire
